// ### hw/lbs_pkg.sv
// Shared constants and types for the light beam scan sequencer
package lbs_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS  = 50;
	localparam int US_NS          = 1000;
	localparam int CYC_PER_US     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_MIN_US  = 60;
	localparam int SLOW_POLL_US   = 60;
	localparam int POLL_HALF_BITS = 31;
	// Register byte offsets
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_ADDR   = 8'h04;
	localparam logic [7:0] ADR_TIMING = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;
	localparam logic [7:0] ADR_RESULT = 8'h10;
	// Field positions
	localparam int CTRL_ROLE_BIT  = 0;
	localparam int CTRL_SET_LSB   = 1;
	localparam int CTRL_RATE_LSB  = 4;
	localparam int TIM_STAMP_LSB  = 0;
	localparam int TIM_WIDTH_LSB  = 8;
	localparam int STAT_CNT_LSB   = 8;
	localparam int STAT_ERR_LSB   = 16;
	localparam int STAT_NEW_BIT   = 20;
	localparam int ERR_SETTLE_BIT = 0;
	localparam int ERR_RATE_BIT   = 1;
	localparam int ERR_TSEL_BIT   = 2;
	// Values after reset
	localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
	localparam logic [9:0]  RST_ADDR   = 10'h000;
	localparam logic [7:0]  RST_STAMP  = 8'h1F;
	localparam logic [7:0]  RST_WIDTH  = 8'h02;
	// Sequence states
	typedef enum logic [2:0] {
		LBS_STANDBY = 3'b000,
		LBS_SETTLE  = 3'b001,
		LBS_WINDOW  = 3'b010,
		LBS_RESULT  = 3'b011
	} lbs_state_t;
endpackage : lbs_pkg

// ### hw/lbs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module lbs_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	if (WIDTH < 1) begin : g_chk
		$error("lbs_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : lbs_sync
`default_nettype wire

// ### hw/lbs_us_tick.sv
// One microsecond reference tick generator
`timescale 1ns/1ps
`default_nettype none
module lbs_us_tick #(
	parameter int DIV = lbs_pkg::CYC_PER_US
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	output var  logic us_tick
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic       nxt_tick;

	if (DIV < 1 || DIV > 255) begin : g_chk
		$error("lbs_us_tick: DIV out of range");
	end

	// Wrap at DIV-1 and flag the wrap
	always_comb begin
		nxt_tick = (cnt_ff == 8'(DIV - 1));
		nxt_cnt  = nxt_tick ? 8'h00 : 8'(cnt_ff + 8'h01);
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt_ff  <= 8'h00;
			us_tick <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			us_tick <= nxt_tick;
		end
	end
endmodule : lbs_us_tick
`default_nettype wire

// ### hw/lbs_sequencer.sv
// Beam poll sequencer of one light-barrier element with Wishbone registers
// Function
// - First addressed poll wakes; settle at least 60us
// - Receiver: second poll opens reception window
// - Receiver: third poll closes window, result state
// - Fourth poll retrieves stored reception results
// - Emitter: second poll, delay, one pulse
// - Emitter: third poll enters result state
// - Count polls; result at n+settle+3
// - Selection zero settles one poll interval
// - Arrival stamp four bits, 0000 to 1111
// - Stamp window sets arrival measuring span
// - Window length is second-to-third poll spacing
// - Rate divider takes values 1 to 8
// - Receiver addressed again at window end: keep waiting
// - Non-poll command during scan forces standby
// - Address zero poll returns results, no start
// - Stamp window equal interval: pulse mid-window
// - Settle selection 000 slow, 001 fast polls
// - Result: new, stamp, thresholds, address, error
`timescale 1ns/1ps
`default_nettype none
module lbs_sequencer #(
	parameter int ADDR_W = 10
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic        wb_ack_o,
	output var  logic [31:0] wb_dat_o,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_is_poll,
	input  wire logic [9:0]  cmd_addr,
	input  wire logic        photo_normal,
	input  wire logic        photo_reserve,
	output var  logic        led_drive,
	output var  logic        rx_window,
	output var  logic        result_valid,
	output var  logic [20:0] result_data
);
	if (ADDR_W < 1 || ADDR_W > 10) begin : g_chk
		$error("lbs_sequencer: ADDR_W must be 1..10");
	end

	logic              us_tick;
	logic [1:0]        photo_s;
	lbs_pkg::lbs_state_t state_ff, nxt_state;
	logic [31:0]       ctrl_ff, nxt_ctrl;
	logic [9:0]        addr_ff, nxt_addr;
	logic [7:0]        stamp_win_ff, nxt_stamp_win;
	logic [7:0]        width_ff, nxt_width;
	logic              ack_ff, nxt_ack;
	logic [31:0]       rdat_ff, nxt_rdat;
	logic [7:0]        poll_cnt_ff, nxt_poll_cnt;
	logic [7:0]        start_ff, nxt_start;
	logic [6:0]        settle_us_ff, nxt_settle_us;
	logic [8:0]        gap_us_ff, nxt_gap_us;
	logic              seen_ff, nxt_seen;
	logic [3:0]        err_ff, nxt_err;
	logic              new_ff, nxt_new;
	logic [3:0]        stamp_ff, nxt_stamp;
	logic [3:0]        run_ff, nxt_run;
	logic [15:0]       step_ff, nxt_step;
	logic              hit_n_ff, nxt_hit_n;
	logic              hit_r_ff, nxt_hit_r;
	logic              photo_d_ff;
	logic [9:0]        win_us_ff, nxt_win_us;
	logic [7:0]        win_sub_ff, nxt_win_sub;
	logic              fired_ff, nxt_fired;
	logic              led_ff, nxt_led;
	logic              rxw_ff, nxt_rxw;
	logic              rv_ff, nxt_rv;
	logic [20:0]       rd_ff, nxt_rd;

	logic              poll, other_cmd, mine, role_emit;
	logic [2:0]        set_sel, rate_sel;
	logic [7:0]        off, t_open;
	logic [15:0]       step_len;
	logic [9:0]        p_delay, p_end;

	lbs_us_tick u_tick (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.us_tick (us_tick)
	);

	lbs_sync #(.WIDTH(2)) u_sync (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.async_in ({photo_reserve, photo_normal}),
		.sync_out (photo_s)
	);

	// Decode of the incoming command and the configured fields
	always_comb begin
		poll      = cmd_valid && cmd_is_poll;
		other_cmd = cmd_valid && !cmd_is_poll;
		mine      = poll && (cmd_addr != 10'h000)
			&& (cmd_addr[ADDR_W-1:0] == addr_ff[ADDR_W-1:0]);
		role_emit = ctrl_ff[lbs_pkg::CTRL_ROLE_BIT];
		set_sel   = ctrl_ff[lbs_pkg::CTRL_SET_LSB +: 3];
		// field holds k-1, k 1 to 8
		rate_sel  = ctrl_ff[lbs_pkg::CTRL_RATE_LSB +: 3];
		off       = 8'(poll_cnt_ff - start_ff);
		t_open    = 8'({5'h00, set_sel} + 8'h01);
		// Step of 1/16 stamp window, never zero cycles
		step_len  = 16'((stamp_win_ff * 16'(lbs_pkg::CYC_PER_US)) >> 4);
		if (step_len == 16'h0000) begin
			step_len = 16'h0001;
		end
		p_delay   = {3'h0, stamp_win_ff[7:1]};
		p_end     = 10'(p_delay + {2'h0, width_ff});
	end

	// Wishbone slave: ack one cycle after request, write at the ack edge
	always_comb begin
		nxt_ack       = wb_cyc_i && wb_stb_i && !ack_ff;
		nxt_ctrl      = ctrl_ff;
		nxt_addr      = addr_ff;
		nxt_stamp_win = stamp_win_ff;
		nxt_width     = width_ff;
		nxt_rdat      = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && ack_ff && wb_we_i) begin
			if (wb_adr_i == lbs_pkg::ADR_CTRL && wb_sel_i[0]) begin
				nxt_ctrl = {25'h000_0000, wb_dat_i[6:0]};
			end
			if (wb_adr_i == lbs_pkg::ADR_ADDR) begin
				if (wb_sel_i[0]) nxt_addr[7:0] = wb_dat_i[7:0];
				if (wb_sel_i[1]) nxt_addr[9:8] = wb_dat_i[9:8];
			end
			if (wb_adr_i == lbs_pkg::ADR_TIMING) begin
				if (wb_sel_i[0]) nxt_stamp_win = wb_dat_i[7:0];
				if (wb_sel_i[1]) nxt_width = wb_dat_i[15:8];
			end
		end
		case (wb_adr_i)
			lbs_pkg::ADR_CTRL:   nxt_rdat = ctrl_ff;
			lbs_pkg::ADR_ADDR:   nxt_rdat = {22'h00_0000, addr_ff};
			lbs_pkg::ADR_TIMING: nxt_rdat = {16'h0000, width_ff, stamp_win_ff};
			lbs_pkg::ADR_STATUS: nxt_rdat = {11'h000, new_ff, err_ff, poll_cnt_ff,
				5'h00, state_ff};
			lbs_pkg::ADR_RESULT: nxt_rdat = {11'h000, rd_ff};
			default:             nxt_rdat = 32'h0000_0000; // Unmapped reads zero
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ack_ff       <= 1'b0;
			rdat_ff      <= 32'h0000_0000;
			ctrl_ff      <= lbs_pkg::RST_CTRL;
			addr_ff      <= lbs_pkg::RST_ADDR;
			stamp_win_ff <= lbs_pkg::RST_STAMP;
			width_ff     <= lbs_pkg::RST_WIDTH;
		end else begin
			ack_ff       <= nxt_ack;
			rdat_ff      <= nxt_rdat;
			ctrl_ff      <= nxt_ctrl;
			addr_ff      <= nxt_addr;
			stamp_win_ff <= nxt_stamp_win;
			width_ff     <= nxt_width;
		end
	end

	// Sequence control driven by the poll count
	always_comb begin
		nxt_state     = state_ff;
		nxt_start     = start_ff;
		nxt_err       = err_ff;
		nxt_new       = new_ff;
		nxt_rxw       = 1'b0;
		nxt_rv        = 1'b0;
		nxt_rd        = rd_ff;
		nxt_seen      = seen_ff || poll;
		nxt_poll_cnt  = poll ? 8'(poll_cnt_ff + 8'h01) : poll_cnt_ff;
		nxt_gap_us    = poll ? 9'h000
			: ((us_tick && gap_us_ff != 9'h1FF) ? 9'(gap_us_ff + 9'h001) : gap_us_ff);
		nxt_settle_us = (us_tick && settle_us_ff != 7'h7F)
			? 7'(settle_us_ff + 7'h01) : settle_us_ff;
		// flag polls closer than 31us times divider
		if (poll && seen_ff && state_ff != lbs_pkg::LBS_STANDBY
			&& gap_us_ff < 9'(lbs_pkg::POLL_HALF_BITS * ({6'h00, rate_sel} + 9'h001))) begin
			nxt_err[lbs_pkg::ERR_RATE_BIT] = 1'b1;
		end
		// selection must match the poll interval
		if (poll && seen_ff && state_ff != lbs_pkg::LBS_STANDBY
			&& ((gap_us_ff >= 9'(lbs_pkg::SLOW_POLL_US)) != (set_sel == 3'h0))) begin
			nxt_err[lbs_pkg::ERR_TSEL_BIT] = 1'b1;
		end
		case (state_ff)
			lbs_pkg::LBS_STANDBY: begin
				if (mine) begin
					nxt_state     = lbs_pkg::LBS_SETTLE;
					nxt_start     = poll_cnt_ff;
					nxt_settle_us = 7'h00;
					nxt_err       = 4'h0;
				end
			end
			lbs_pkg::LBS_SETTLE: begin
				// open after settle_delay_sel+1 polls, once settled
				if (poll && off == t_open) begin
					if (settle_us_ff >= 7'(lbs_pkg::SETTLE_MIN_US)) begin
						nxt_state = lbs_pkg::LBS_WINDOW;
						nxt_rxw   = !role_emit;
					end else begin
						nxt_start = 8'(start_ff + 8'h01);
						nxt_err[lbs_pkg::ERR_SETTLE_BIT] = 1'b1;
					end
				end
			end
			lbs_pkg::LBS_WINDOW: begin
				nxt_rxw = !role_emit;
				if (poll && off == 8'(t_open + 8'h01)) begin
					if (mine && !role_emit) begin
						nxt_start = 8'(start_ff + 8'h01);
					end else begin
						nxt_state = lbs_pkg::LBS_RESULT;
						nxt_rxw   = 1'b0;
						nxt_new   = 1'b1;
					end
				end
			end
			lbs_pkg::LBS_RESULT: begin
				if (poll && off == 8'(t_open + 8'h02)) begin
					nxt_state = lbs_pkg::LBS_STANDBY;
				end
			end
			default: nxt_state = lbs_pkg::LBS_STANDBY;
		endcase
		if (other_cmd) begin
			nxt_state = lbs_pkg::LBS_STANDBY;
			nxt_rxw   = 1'b0;
		end
		if ((state_ff == lbs_pkg::LBS_RESULT && poll && off == 8'(t_open + 8'h02))
			|| (poll && cmd_addr == 10'h000)) begin
			nxt_rv  = 1'b1;
			nxt_rd  = {nxt_new, stamp_ff, hit_n_ff, hit_r_ff, addr_ff, err_ff};
			nxt_new = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_ff     <= lbs_pkg::LBS_STANDBY;
			start_ff     <= 8'h00;
			err_ff       <= 4'h0;
			new_ff       <= 1'b0;
			rxw_ff       <= 1'b0;
			rv_ff        <= 1'b0;
			rd_ff        <= 21'h00_0000;
			seen_ff      <= 1'b0;
			poll_cnt_ff  <= 8'h00;
			gap_us_ff    <= 9'h000;
			settle_us_ff <= 7'h00;
		end else begin
			state_ff     <= nxt_state;
			start_ff     <= nxt_start;
			err_ff       <= nxt_err;
			new_ff       <= nxt_new;
			rxw_ff       <= nxt_rxw;
			rv_ff        <= nxt_rv;
			rd_ff        <= nxt_rd;
			seen_ff      <= nxt_seen;
			poll_cnt_ff  <= nxt_poll_cnt;
			gap_us_ff    <= nxt_gap_us;
			settle_us_ff <= nxt_settle_us;
		end
	end

	// Arrival stamp and emitter pulse timing inside the window
	always_comb begin
		nxt_run   = run_ff;
		nxt_step  = step_ff;
		nxt_stamp = stamp_ff;
		nxt_hit_n = hit_n_ff;
		nxt_hit_r = hit_r_ff;
		nxt_win_us = win_us_ff;
		nxt_win_sub = win_sub_ff;
		nxt_fired = fired_ff;
		nxt_led   = 1'b0;
		if (state_ff != lbs_pkg::LBS_WINDOW) begin
			// Restart the measure whenever the window is shut
			nxt_run    = 4'h0;
			nxt_step   = 16'h0000;
			nxt_win_us = 10'h000;
			nxt_win_sub = 8'h00;
			nxt_fired  = 1'b0;
			if (nxt_state == lbs_pkg::LBS_WINDOW) begin
				nxt_stamp = 4'h0;
				nxt_hit_n = 1'b0;
				nxt_hit_r = 1'b0;
			end
		end else begin
			// 16 steps across stamp window, saturating
			if (step_ff >= 16'(step_len - 16'h0001)) begin
				nxt_step = 16'h0000;
				nxt_run  = (run_ff == 4'hF) ? 4'hF : 4'(run_ff + 4'h1);
			end else begin
				nxt_step = 16'(step_ff + 16'h0001);
			end
			// Microseconds from the opening edge, not the free tick,
			// so the pulse does not wander with the tick phase
			if (win_sub_ff == 8'(lbs_pkg::CYC_PER_US - 1)) begin
				nxt_win_sub = 8'h00;
				if (win_us_ff != 10'h3FF) begin
					nxt_win_us = 10'(win_us_ff + 10'h001);
				end
			end else begin
				nxt_win_sub = 8'(win_sub_ff + 8'h01);
			end
			// first normal-threshold edge latches the stamp
			if (!role_emit && photo_s[0] && !photo_d_ff && !hit_n_ff) begin
				nxt_hit_n = 1'b1;
				nxt_stamp = run_ff;
			end
			if (!role_emit && photo_s[1]) begin
				nxt_hit_r = 1'b1;
			end
			// single pulse at half stamp window
			if (role_emit && !fired_ff && win_us_ff >= p_delay && win_us_ff < p_end) begin
				nxt_led = 1'b1;
			end
			if (role_emit && win_us_ff >= p_end) begin
				nxt_fired = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			run_ff     <= 4'h0;
			step_ff    <= 16'h0000;
			stamp_ff   <= 4'h0;
			hit_n_ff   <= 1'b0;
			hit_r_ff   <= 1'b0;
			photo_d_ff <= 1'b0;
			win_us_ff  <= 10'h000;
			win_sub_ff <= 8'h00;
			fired_ff   <= 1'b0;
			led_ff     <= 1'b0;
		end else begin
			run_ff     <= nxt_run;
			step_ff    <= nxt_step;
			stamp_ff   <= nxt_stamp;
			hit_n_ff   <= nxt_hit_n;
			hit_r_ff   <= nxt_hit_r;
			photo_d_ff <= photo_s[0];
			win_us_ff  <= nxt_win_us;
			win_sub_ff <= nxt_win_sub;
			fired_ff   <= nxt_fired;
			led_ff     <= nxt_led;
		end
	end

	// Outputs straight from flops
	always_comb begin
		wb_ack_o     = ack_ff;
		wb_dat_o     = rdat_ff;
		led_drive    = led_ff;
		rx_window    = rxw_ff;
		result_valid = rv_ff;
		result_data  = rd_ff;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	wake_on_poll_a: assert property (
		state_ff == lbs_pkg::LBS_STANDBY && mine && !other_cmd
		|=> state_ff == lbs_pkg::LBS_SETTLE) else $error("no wake on addressed poll");
	settle_min_a: assert property (
		state_ff == lbs_pkg::LBS_SETTLE ##1 state_ff == lbs_pkg::LBS_WINDOW
		|-> $past(settle_us_ff) >= 7'd60) else $error("window opened before settling");
	window_open_a: assert property (
		state_ff == lbs_pkg::LBS_SETTLE && poll && off == t_open && !role_emit
		&& settle_us_ff >= 7'd60 |=> rx_window) else $error("window not opened");
	window_close_a: assert property (
		state_ff == lbs_pkg::LBS_WINDOW && poll && !mine && !other_cmd
		&& off == 8'(t_open + 8'h01)
		|=> state_ff == lbs_pkg::LBS_RESULT && !rx_window ##1 !rx_window)
		else $error("window not closed");
	result_time_a: assert property (
		state_ff == lbs_pkg::LBS_RESULT && poll && off == 8'(t_open + 8'h02)
		|=> result_valid && result_data[20]) else $error("result not presented");
	abort_other_a: assert property (
		other_cmd |=> state_ff == lbs_pkg::LBS_STANDBY && !rx_window)
		else $error("scan not aborted");
	addr_zero_a: assert property (
		state_ff == lbs_pkg::LBS_STANDBY && poll && cmd_addr == 10'h000
		|=> result_valid && state_ff == lbs_pkg::LBS_STANDBY) else $error("address zero misuse");
	keep_waiting_a: assert property (
		state_ff == lbs_pkg::LBS_WINDOW && mine && !role_emit && off == 8'(t_open + 8'h01)
		|=> state_ff == lbs_pkg::LBS_WINDOW) else $error("window shut on readdress");
	poll_count_a: assert property (
		poll |=> poll_cnt_ff == 8'($past(poll_cnt_ff) + 8'h01)) else $error("poll not counted");
	led_owner_a: assert property (
		$rose(led_drive) |-> $past(state_ff) == lbs_pkg::LBS_WINDOW && role_emit
		##1 !$rose(led_drive)) else $error("stray light pulse");
	stamp_hold_a: assert property (
		state_ff == lbs_pkg::LBS_WINDOW && run_ff == 4'hF && nxt_state == lbs_pkg::LBS_WINDOW
		|=> run_ff == 4'hF) else $error("stamp wrapped");

	rx_scan_c: cover property (state_ff == lbs_pkg::LBS_WINDOW && hit_n_ff ##[1:400] result_valid);
	emit_pulse_c: cover property ($rose(led_drive));
	extend_c: cover property (state_ff == lbs_pkg::LBS_WINDOW && mine
		&& off == 8'(t_open + 8'h01));
endmodule : lbs_sequencer
`default_nettype wire

// ### dv/lbs_ctrl_model.sv
// Bus controller model issuing decoded commands to one element
`timescale 1ns/1ps
`default_nettype none
module lbs_ctrl_model #(
	parameter int GAP = 1200
) (
	input  wire logic       sys_clk,
	output var  logic       cmd_valid,
	output var  logic       cmd_is_poll,
	output var  logic [9:0] cmd_addr
);
	// Quiet bus at start
	initial begin
		cmd_valid   = 1'b0;
		cmd_is_poll = 1'b0;
		cmd_addr    = 10'h3FF;
	end
	// spaced commands
	// Gap of 60us keeps above the 31us floor and sets window length
	task automatic send(input logic poll, input logic [9:0] a);
		repeat (GAP) @(posedge sys_clk);
		cmd_valid   <= 1'b1;
		cmd_is_poll <= poll;
		cmd_addr    <= a;
		@(posedge sys_clk);
		cmd_valid   <= 1'b0;
		// Released lines carry garbage, never the last command
		cmd_is_poll <= ~poll;
		cmd_addr    <= ~a;
	endtask : send
endmodule : lbs_ctrl_model
`default_nettype wire

// ### dv/lbs_sequencer_tb.sv
// Self-checking bench for the light beam scan sequencer
`timescale 1ns/1ps
`default_nettype none
module lbs_sequencer_tb;
	logic        sys_clk;
	logic        reset_n;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	logic        cmd_valid;
	logic        cmd_is_poll;
	logic [9:0]  cmd_addr;
	logic        photo_normal;
	logic        photo_reserve;
	logic        led_drive;
	logic        rx_window;
	logic        result_valid;
	logic [20:0] result_data;
	logic        led_q;
	logic [31:0] rd;
	logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
	logic [31:0] re [5] = '{32'h0, 32'h0, 32'h0000_021F, 32'h0, 32'h0};
	int          fails = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          rv_cnt = 0;
	int          led_cnt = 0;
	int          led_len = 0;
	int          led_rise = 0;
	int          last = 0;
	int          pc = 0;
	int          r0;
	lbs_sequencer u_lbs_sequencer (.sys_clk(sys_clk), .reset_n(reset_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.cmd_valid(cmd_valid), .cmd_is_poll(cmd_is_poll), .cmd_addr(cmd_addr),
		.photo_normal(photo_normal), .photo_reserve(photo_reserve), .led_drive(led_drive),
		.rx_window(rx_window), .result_valid(result_valid), .result_data(result_data));
	lbs_ctrl_model u_lbs_ctrl_model (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
		.cmd_is_poll(cmd_is_poll), .cmd_addr(cmd_addr));
	// Free-running 20 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Cycle count, result pulses and LED pulse shape
	always @(posedge sys_clk) begin
		cyc   <= cyc + 1;
		led_q <= led_drive;
		if (result_valid === 1'b1)
			rv_cnt <= rv_cnt + 1;
		if (led_drive === 1'b1)
			led_len <= led_len + 1;
		if (led_drive === 1'b1 && led_q !== 1'b1) begin
			led_cnt  <= led_cnt + 1;
			led_rise <= cyc;
		end
	end
	task automatic end_of_test();
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check
	// Classic single Wishbone cycle, entered just after a rising edge
	task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1) @(posedge sys_clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask : wb_io
	task automatic state_is(input logic [2:0] e);
		wb_io(1'b0, lbs_pkg::ADR_STATUS, 32'h0);
		check("state", {29'h0, rd[2:0]}, {29'h0, e});
	endtask : state_is
	// Poll, then let the registered outputs settle
	task automatic poll(input logic [9:0] a);
		u_lbs_ctrl_model.send(1'b1, a);
		pc++;
		last = cyc;
		repeat (3) @(posedge sys_clk);
	endtask : poll
	// Receiver sequence with a light edge d cycles into the window
	task automatic rx_run(input int d, input logic [3:0] st);
		poll(10'h005);
		state_is(3'h1);
		poll(10'h007);
		check("rx_window open", {31'h0, rx_window}, 32'h1);
		fork
			begin
				repeat (d) @(posedge sys_clk);
				photo_normal <= 1'b1;
			end
		join_none
		r0 = rv_cnt;
		poll(10'h009);
		photo_normal <= 1'b0;
		check("rx_window shut", {31'h0, rx_window}, 32'h0);
		poll(10'h00B);
		check("result pulses", rv_cnt, r0 + 1);
		check("result", {11'h0, result_data}, {11'h0, 1'b1, st, 2'b10, 10'h005, 4'h0});
		state_is(3'h0);
	endtask : rx_run
	initial begin
		reset_n       = 1'b0;
		wb_cyc_i      = 1'b0;
		wb_stb_i      = 1'b0;
		wb_we_i       = 1'b0;
		wb_adr_i      = 8'h00;
		wb_sel_i      = 4'h0;
		wb_dat_i      = 32'h0;
		photo_normal  = 1'b0;
		photo_reserve = 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		// Reset values, unmapped write and read-only write
		wb_io(1'b1, 8'h14, 32'hFFFF_FFFF);
		wb_io(1'b1, lbs_pkg::ADR_STATUS, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++) begin
			wb_io(1'b0, ra[i], 32'h0);
			check("register", rd, re[i]);
		end
		// stamp window equal to the 60us poll spacing
		wb_io(1'b1, lbs_pkg::ADR_TIMING, 32'h0000_023C);
		wb_io(1'b1, lbs_pkg::ADR_ADDR, 32'h0000_0005);
		// Steps of 75 cycles: mid-window and late edges
		rx_run(634, 4'h8);
		rx_run(1130, 4'hF);
		// Non-poll during settle drops to standby; next poll opens nothing
		poll(10'h005);
		u_lbs_ctrl_model.send(1'b0, 10'h005);
		repeat (3) @(posedge sys_clk);
		state_is(3'h0);
		poll(10'h007);
		check("rx_window after abort", {31'h0, rx_window}, 32'h0);
		// Fetch-only poll presents old word with new cleared
		r0 = rv_cnt;
		poll(10'h000);
		check("fetch pulses", rv_cnt, r0 + 1);
		check("fetch word", {27'h0, result_data[20:16]}, 32'h0000_000F);
		state_is(3'h0);
		wb_io(1'b0, lbs_pkg::ADR_STATUS, 32'h0);
		check("poll count", {24'h0, rd[15:8]}, pc & 32'h0000_00FF);
		// Readdressed at window end: window stays one more poll
		poll(10'h005);
		poll(10'h007);
		poll(10'h005);
		check("rx_window kept", {31'h0, rx_window}, 32'h1);
		state_is(3'h2);
		photo_reserve <= 1'b1;
		poll(10'h009);
		photo_reserve <= 1'b0;
		check("rx_window late shut", {31'h0, rx_window}, 32'h0);
		poll(10'h00B);
		check("late result", {11'h0, result_data}, 32'h0010_4050);
		// Emitter: one 2us pulse in the middle of the window
		wb_io(1'b1, lbs_pkg::ADR_ADDR, 32'h0000_0003);
		wb_io(1'b1, lbs_pkg::ADR_CTRL, 32'h0000_0001);
		led_cnt = 0;
		led_len = 0;
		poll(10'h003);
		poll(10'h007);
		r0 = last;
		poll(10'h009);
		check("led pulses", led_cnt, 1);
		check("led width", led_len, 40);
		check("led centred", (led_rise - r0) inside {[598:604]}, 1);
		state_is(3'h3);
		poll(10'h00B);
		state_is(3'h0);
		end_of_test();
	end
	// Hang guard, well beyond the 25k cycles the tests need
	initial begin
		repeat (40000) @(posedge sys_clk);
		fails++;
		end_of_test();
	end
endmodule : lbs_sequencer_tb
`default_nettype wire
